/* rtl/esx_pkg.sv */
// esx_pkg: constants and types for the simplex expansion bus access timer
// assumes one 25 MHz clock that is also the expansion bus clock
// How it works
// - address is presented one to four bus cycles before chip select asserts.
// - write data is driven one to four cycles before strobe falls.
// - strobe stays low for a programmed one to sixteen cycles.
// - data stays valid one to four cycles after strobe rises.
// - address latch enable has no meaning here and is held low.
// - address phase count sets how long address shows before access proceeds.
// - data setup count sets how long data shows before strobe asserts.
// - strobe count sets strobe low time; data stays available meanwhile.
// - hold count keeps chip select, address and write data after strobe.
// - recovery count sets the idle gap between successive accesses.
// - every phase is counted in expansion bus clock cycles.
// - recovery gap is programmable from one to sixteen cycles.
package esx_pkg;
    localparam int ADDR_W      = 24;
    localparam int DATA_W      = 16;
    localparam int SHORT_CNT_W = 2;   // field code 0..3 means 1..4 cycles
    localparam int LONG_CNT_W  = 4;   // field code 0..15 means 1..16 cycles
    localparam int CLOCK_MHZ   = 25;

    typedef enum logic [2:0] {
        ESX_IDLE,
        ESX_ADDR,
        ESX_SETUP,
        ESX_STROBE,
        ESX_HOLD,
        ESX_RECOV
    } esx_state_t;

    typedef struct packed {
        logic [SHORT_CNT_W-1:0] address_phase_count;
        logic [SHORT_CNT_W-1:0] data_setup_phase_count;
        logic [LONG_CNT_W-1:0]  strobe_phase_count;
        logic [SHORT_CNT_W-1:0] hold_phase_count;
        logic [LONG_CNT_W-1:0]  recovery_phase_count;
    } esx_timing_t;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } esx_req_t;
endpackage : esx_pkg

/* rtl/esx_phase_counter.sv */
// esx_phase_counter: down counter that times one bus phase
// assumes load and count come from the same clock domain
`timescale 1ns/100ps
module esx_phase_counter (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic                          load,
    input  wire logic [esx_pkg::LONG_CNT_W-1:0] load_value,
    output logic                               last
);
    import esx_pkg::*;

    logic [LONG_CNT_W-1:0] count;
    logic [LONG_CNT_W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (count != 4'h0) begin
            next_count = count - 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count <= 4'h0;
        end else begin
            count <= next_count;
        end
    end

    // code n gives n+1 cycles in a phase
    assign last = (count == 4'h0);
endmodule : esx_phase_counter

/* rtl/esx_simplex_timer.sv */
// esx_simplex_timer: simplex strobe mode access sequencer for the expansion bus
// assumes requester and external read data share the bus clock; rd pin data is synchronised
`timescale 1ns/100ps
module esx_simplex_timer (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire esx_pkg::esx_timing_t       timing,
    input  wire logic                       req_valid,
    output logic                            req_ready,
    input  wire esx_pkg::esx_req_t          req,
    output logic                            rsp_valid,
    output logic [esx_pkg::DATA_W-1:0]      rsp_rdata,
    output logic                            busy,
    output logic [esx_pkg::ADDR_W-1:0]      bus_addr,
    output logic                            chip_select_n,
    output logic                            data_strobe_n,
    output logic                            bus_write,
    output logic [esx_pkg::DATA_W-1:0]      bus_wdata,
    output logic                            bus_wdata_oe,
    input  wire logic [esx_pkg::DATA_W-1:0] bus_rdata,
    output logic                            address_latch_enable
);
    import esx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // read data pin synchroniser
    logic [DATA_W-1:0] rd_meta;
    logic [DATA_W-1:0] rd_sync;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_meta <= 16'h0000;
            rd_sync <= 16'h0000;
        end else begin
            rd_meta <= bus_rdata;
            rd_sync <= rd_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // phase sequencer
    esx_state_t            state;
    esx_state_t            next_state;
    esx_timing_t           tim;
    esx_timing_t           next_tim;
    esx_req_t              cur;
    esx_req_t              next_cur;
    logic                  ph_load;
    logic [LONG_CNT_W-1:0] ph_value;
    logic                  ph_last;
    logic [DATA_W-1:0]     next_rsp_rdata;
    logic                  next_rsp_valid;

    esx_phase_counter u_phase (
        .clock      (clock),
        .rst_n      (rst_n),
        .load       (ph_load),
        .load_value (ph_value),
        .last       (ph_last)
    );

    assign req_ready = (state == ESX_IDLE);

    always_comb begin
        next_state     = state;
        next_tim       = tim;
        next_cur       = cur;
        ph_load        = 1'b0;
        ph_value       = 4'h0;
        unique case (state)
            ESX_IDLE: begin
                if (req_valid) begin
                    next_tim   = timing;  // settings frozen per access
                    next_cur   = req;
                    ph_load    = 1'b1;
                    ph_value   = {2'b00, timing.address_phase_count};
                    next_state = ESX_ADDR;
                end
            end
            ESX_ADDR: begin
                if (ph_last) begin
                    ph_load    = 1'b1;
                    ph_value   = {2'b00, tim.data_setup_phase_count};
                    next_state = ESX_SETUP;
                end
            end
            ESX_SETUP: begin
                if (ph_last) begin
                    ph_load    = 1'b1;
                    ph_value   = tim.strobe_phase_count;
                    next_state = ESX_STROBE;
                end
            end
            ESX_STROBE: begin
                if (ph_last) begin
                    ph_load    = 1'b1;
                    ph_value   = {2'b00, tim.hold_phase_count};
                    next_state = ESX_HOLD;
                end
            end
            ESX_HOLD: begin
                if (ph_last) begin
                    ph_load        = 1'b1;
                    ph_value       = tim.recovery_phase_count;
                    next_state     = ESX_RECOV;
                end
            end
            ESX_RECOV: begin
                if (ph_last) begin
                    next_state = ESX_IDLE;
                end
            end
            default: begin
                // an upset state code falls back to idle
                next_state = ESX_IDLE;
            end
        endcase
    end

    // read data comes from the second synchroniser flop, so a read needs setup plus strobe
    // of three cycles or more for the pin value to have crossed by the strobe end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= ESX_IDLE;
            tim   <= '0;
            cur   <= '0;
        end else begin
            state <= next_state;
            tim   <= next_tim;
            cur   <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // response: read data is taken at the last strobe cycle
    // rsp_valid pulses once at hold end, for writes too
    always_comb begin
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        if ((state == ESX_STROBE) && ph_last && !cur.write) begin
            next_rsp_rdata = rd_sync;
        end
        if ((state == ESX_HOLD) && ph_last) begin
            next_rsp_valid = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // registered pin drive
    logic              next_cs_n;
    logic              next_ds_n;
    logic              next_oe;
    logic              next_busy;

    // pins follow the state they enter, so each phase lasts exactly its count plus one cycles
    // write data drives only under chip select, so its lead on the strobe is the setup count plus one cycles
    always_comb begin
        next_cs_n = 1'b1;
        next_ds_n = 1'b1;
        next_oe   = 1'b0;
        next_busy = 1'b1;
        unique case (next_state)
            ESX_IDLE: begin
                next_busy = 1'b0;
            end
            ESX_ADDR: begin
                next_cs_n = 1'b1;
            end
            ESX_SETUP: begin
                next_cs_n = 1'b0;
                next_oe   = next_cur.write;
            end
            ESX_STROBE: begin
                next_cs_n = 1'b0;
                next_ds_n = 1'b0;
                next_oe   = next_cur.write;
            end
            ESX_HOLD: begin
                next_cs_n = 1'b0;
                next_oe   = next_cur.write;
            end
            ESX_RECOV: begin
                next_busy = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bus_addr      <= 24'h000000;
            chip_select_n <= 1'b1;
            data_strobe_n <= 1'b1;
            bus_write     <= 1'b0;
            bus_wdata     <= 16'h0000;
            bus_wdata_oe  <= 1'b0;
            busy          <= 1'b0;
        end else begin
            bus_addr      <= next_cur.addr;
            chip_select_n <= next_cs_n;
            data_strobe_n <= next_ds_n;
            bus_write     <= next_cur.write;
            bus_wdata     <= next_cur.wdata;
            bus_wdata_oe  <= next_oe;
            busy          <= next_busy;
        end
    end

    assign address_latch_enable = 1'b0;
endmodule : esx_simplex_timer

/* sim/esx_simplex_timer_asserts.sv */
// esx_simplex_timer_asserts: phase length checks on the sequencer ports
// assumes timing stays fixed while an access runs
`timescale 1ns/100ps
module esx_simplex_timer_asserts (
    input wire logic                     clock,
    input wire logic                     rst_n,
    input wire esx_pkg::esx_timing_t     timing,
    input wire logic                     rsp_valid,
    input wire logic                     busy,
    input wire logic [esx_pkg::ADDR_W-1:0] bus_addr,
    input wire logic                     chip_select_n,
    input wire logic                     data_strobe_n,
    input wire logic                     bus_write,
    input wire logic [esx_pkg::DATA_W-1:0] bus_wdata,
    input wire logic                     bus_wdata_oe,
    input wire logic                     address_latch_enable
);
    import esx_pkg::*;
    logic [7:0] run;
    logic [2:0] prev;
    // run length of the pin state one cycle back, so at a change it gives the length of the state just left
    always_ff @(posedge clock) begin
        run  <= (rst_n && {busy, chip_select_n, data_strobe_n} == prev) ? run + 8'h01 : 8'h01;
        prev <= rst_n ? {busy, chip_select_n, data_strobe_n} : 3'b011;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_addr_lead: assert property ($fell(chip_select_n) |-> run == timing.address_phase_count + 8'h01)
        else $error("address lead wrong");
    a_setup_len: assert property ($fell(data_strobe_n) |-> !chip_select_n && run == timing.data_setup_phase_count + 8'h01)
        else $error("setup length wrong");
    a_strobe_len: assert property ($rose(data_strobe_n) |-> run == timing.strobe_phase_count + 8'h01)
        else $error("strobe length wrong");
    a_hold_len: assert property ($rose(chip_select_n) |-> rsp_valid && run == timing.hold_phase_count + 8'h01)
        else $error("hold length wrong");
    a_recov_len: assert property ($fell(busy) |-> chip_select_n && run == timing.recovery_phase_count + 8'h01)
        else $error("recovery length wrong");
    a_ale_idle: assert property (address_latch_enable == 1'b0)
        else $error("latch enable driven");
    a_addr_steady: assert property (!chip_select_n |-> busy && $stable(bus_addr))
        else $error("address moved");
    a_wdata_steady: assert property (!chip_select_n && bus_write |-> bus_wdata_oe && $stable(bus_wdata))
        else $error("write data moved");
    a_oe_window: assert property (bus_wdata_oe |-> !chip_select_n && bus_write)
        else $error("write data driven outside select");
    a_phase_order: assert property (!data_strobe_n |-> !chip_select_n ##1 !chip_select_n)
        else $error("strobe outside select");
    c_write: cover property ($rose(data_strobe_n) && bus_write);
    c_read: cover property ($rose(data_strobe_n) && !bus_write);
    c_long_recov: cover property ($fell(busy) && run == 8'h10);
endmodule : esx_simplex_timer_asserts
bind esx_simplex_timer esx_simplex_timer_asserts i_esx_simplex_timer_asserts (.clock, .rst_n, .timing,
    .rsp_valid, .busy, .bus_addr, .chip_select_n, .data_strobe_n, .bus_write, .bus_wdata, .bus_wdata_oe,
    .address_latch_enable);

/* sim/esx_periph_model.sv */
// esx_periph_model: sixteen word peripheral on the simplex bus
// assumes the sequencer clock is the bus clock
`timescale 1ns/100ps
module esx_periph_model (
    input wire logic                       clock,
    input wire logic [esx_pkg::ADDR_W-1:0] bus_addr,
    input wire logic                       chip_select_n,
    input wire logic                       data_strobe_n,
    input wire logic                       bus_write,
    input wire logic [esx_pkg::DATA_W-1:0] bus_wdata,
    input wire logic                       bus_wdata_oe,
    output logic [esx_pkg::DATA_W-1:0]     bus_rdata
);
    import esx_pkg::*;
    logic [DATA_W-1:0] mem [16];
    initial foreach (mem[i]) mem[i] = 16'h0000;
    // drive the stored word only while selected for a read, its inverse at all other times
    always_comb bus_rdata = (!chip_select_n && !bus_write) ? mem[bus_addr[3:0]] : ~mem[bus_addr[3:0]];
    // take write data in the strobe; latch enable is never looked at
    always @(posedge clock) if (!data_strobe_n && bus_write && bus_wdata_oe) mem[bus_addr[3:0]] <= bus_wdata;
endmodule : esx_periph_model

/* sim/esx_simplex_timer_test.sv */
// esx_simplex_timer_test: writes and reads through the peripheral model
// assumes the checker is bound to the sequencer
`timescale 1ns/100ps
module esx_simplex_timer_test;
    import esx_pkg::*;
    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    logic              req_valid = 1'b0;
    esx_timing_t       timing = '0;
    esx_req_t          req = '0;
    logic              req_ready, rsp_valid, busy, chip_select_n, data_strobe_n, bus_write, bus_wdata_oe, ale;
    logic [DATA_W-1:0] rsp_rdata, bus_wdata, bus_rdata;
    logic [ADDR_W-1:0] bus_addr;
    int                failures = 0;
    int                num_checks = 0;
    always #20 clock = ~clock;
    esx_simplex_timer i_esx_simplex_timer (.clock(clock), .rst_n(rst_n), .timing(timing), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy),
        .bus_addr(bus_addr), .chip_select_n(chip_select_n), .data_strobe_n(data_strobe_n), .bus_write(bus_write),
        .bus_wdata(bus_wdata), .bus_wdata_oe(bus_wdata_oe), .bus_rdata(bus_rdata), .address_latch_enable(ale));
    esx_periph_model i_esx_periph_model (.clock(clock), .bus_addr(bus_addr), .chip_select_n(chip_select_n),
        .data_strobe_n(data_strobe_n), .bus_write(bus_write), .bus_wdata(bus_wdata), .bus_wdata_oe(bus_wdata_oe),
        .bus_rdata(bus_rdata));
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic access(input logic wr, input logic [3:0] a, input logic [15:0] d);
        int n;
        n = 0;
        while (!req_ready && n < 100) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        req_valid <= 1'b1;
        req <= '{wr, {20'h00000, a}, d};
        @(posedge clock);
        req_valid <= 1'b0;
        @(negedge clock);
        check(req_ready, 1'b0);
        n = 1;
        while (!rsp_valid && n < 100) begin
            @(negedge clock);
            n++;
        end
        check(n, timing.address_phase_count + timing.data_setup_phase_count + timing.strobe_phase_count
            + timing.hold_phase_count + 5);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (!req_ready && n < 100);
        check(n, timing.recovery_phase_count + 1);
    endtask : access
    task automatic t_write_fast();
        @(posedge clock);
        timing <= '0;
        access(1'b1, 4'h3, 16'hA5C3);
        check(i_esx_periph_model.mem[3], 16'hA5C3);
    endtask : t_write_fast
    task automatic t_read_slow();
        @(posedge clock);
        timing <= '{2'h3, 2'h3, 4'hF, 2'h3, 4'hF};
        access(1'b0, 4'h3, 16'h0000);
        check(rsp_rdata, 16'hA5C3);
    endtask : t_read_slow
    task automatic t_mixed_pair();
        @(posedge clock);
        timing <= '{2'h1, 2'h2, 4'h4, 2'h0, 4'h7};
        access(1'b1, 4'hC, 16'h5A3C);
        access(1'b0, 4'hC, 16'h0000);
        check(rsp_rdata, 16'h5A3C);
    endtask : t_mixed_pair
    task automatic summarize();
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        t_write_fast();
        t_read_slow();
        t_mixed_pair();
        summarize();
    end
    initial begin
        repeat (2000) @(posedge clock);
        failures++;
        summarize();
    end
endmodule : esx_simplex_timer_test
